/* clock_selector_pkg.sv */
// Purpose: shared constants for the system clock source selector
// Assumes: 100 MHz supervisory clock sys_clk_in
// Notes: mode codes of the boot clock mode field and runtime select codes
package clock_selector_pkg;

  // ****************************************
  // boot clock mode field codes
  // ****************************************
  localparam logic [2:0] MODE_WATCH_CRYSTAL = 3'h0;
  localparam logic [2:0] MODE_MEDIUM_GAIN = 3'h1;
  localparam logic [2:0] MODE_HIGH_GAIN = 3'h2;
  localparam logic [2:0] MODE_RC = 3'h3;
  localparam logic [2:0] MODE_INTERNAL = 3'h4;
  localparam logic [2:0] MODE_EXT_LOW = 3'h5;
  localparam logic [2:0] MODE_EXT_MED = 3'h6;
  localparam logic [2:0] MODE_EXT_HIGH = 3'h7;
  localparam logic [2:0] MODE_RESET = MODE_INTERNAL;

  // ****************************************
  // runtime clock select and internal frequency select
  // ****************************************
  localparam logic [1:0] SEL_BOOT = 2'h0;
  localparam logic [1:0] SEL_TIMER = 2'h1;
  localparam int SEL_INTERNAL_BIT = 1;
  localparam logic [1:0] IFREQ_FAST = 2'h0;
  localparam logic [1:0] IFREQ_MID = 2'h1;

  // ****************************************
  // amplifier gain codes
  // ****************************************
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_LOW = 2'h1;
  localparam logic [1:0] GAIN_MID = 2'h2;
  localparam logic [1:0] GAIN_HIGH = 2'h3;

  // ****************************************
  // source indices
  // ****************************************
  localparam int NUM_SRC = 5;
  localparam logic [2:0] SRC_PRIMARY = 3'h0;
  localparam logic [2:0] SRC_TIMER = 3'h1;
  localparam logic [2:0] SRC_FAST = 3'h2;
  localparam logic [2:0] SRC_MID = 3'h3;
  localparam logic [2:0] SRC_SLOW = 3'h4;

  // ****************************************
  // timing
  // ****************************************
  localparam logic [10:0] OST_COUNT = 11'h400;
  localparam int CLK_MHZ = 100;
  localparam int FAIL_TIMEOUT_US = 40;
  localparam int FAIL_TIMEOUT_CYC = FAIL_TIMEOUT_US * CLK_MHZ;
  localparam int FAIL_CNT_W = 13;

  typedef enum logic [2:0] {
    SW_RUN = 3'b001,
    SW_DRAIN = 3'b010,
    SW_ADOPT = 3'b100
  } switch_state_t;

endpackage

/* system_clock_source_selector.sv */
// Purpose: system clock source selection, start-up counter and fail-safe monitor
// Assumes: all clock sources arrive as levels sampled by sys_clk_in
// Notes: system_clock_out is the selected source re-timed, switched glitch free
`timescale 1ns/10ps
`default_nettype none

// How it works
// - eight boot clock modes chosen by a three-bit nonvolatile field.
// - external logic clock codes 111 high, 110 medium, 101 low power.
// - external logic clock modes skip the start-up counter entirely.
// - with fail-safe off, halting the external clock freezes output; operation resumes unchanged.
// - boot field source becomes default system clock when reset ends.
// - two-bit runtime select switches between internal and external sources.
// - runtime select can pick the timer oscillator or boot-defined source.
// - fail-safe monitor detects lost external clock, falls back to internal.
// - crystal modes drive low, medium or high amplifier gain.
// - internal block offers fast, mid and slow sources.
// - secondary pin is general I/O or clock out in non-crystal modes.
// - crystal modes wait 1024 input edges after reset or wake-up.
// - multiplier on by nonvolatile bit or software bit; software ignored if nv set.
module system_clock_source_selector #(
  parameter int unsigned FAIL_TIMEOUT_CYCLES = clock_selector_pkg::FAIL_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // nonvolatile configuration
  input wire logic [2:0] boot_clock_mode_field_in,
  input wire logic nv_multiplier_enable_in,
  input wire logic clkout_enable_in,
  input wire logic fail_safe_enable_in,
  input wire logic two_speed_enable_in,
  // oscillator control register bits
  input wire logic [1:0] runtime_clock_select_in,
  input wire logic [1:0] internal_freq_select_in,
  input wire logic sw_multiplier_enable_in,
  input wire logic wake_from_sleep_in,
  // clock sources
  input wire logic primary_osc_input_in,
  input wire logic timer_osc_in,
  input wire logic internal_fast_source_in,
  input wire logic internal_mid_source_in,
  input wire logic internal_slow_source_in,
  // secondary pin and its core-side data
  input wire logic secondary_osc_pin_in,
  input wire logic gpio_data_in,
  input wire logic gpio_drive_in,
  // outputs
  output logic system_clock_out,
  output logic run_enable_out,
  output logic [1:0] gain_select_out,
  output logic multiplier_enable_out,
  output logic clock_failed_out,
  output logic startup_stable_out,
  output logic [2:0] active_source_out,
  output logic secondary_osc_pin_out,
  output logic secondary_osc_pin_oe_out,
  output logic secondary_pin_sample_out
);
  import clock_selector_pkg::*;

  localparam logic [FAIL_CNT_W-1:0] FAIL_LAST = FAIL_CNT_W'(FAIL_TIMEOUT_CYCLES - 1);

  if (FAIL_TIMEOUT_CYCLES < 2 || FAIL_TIMEOUT_CYCLES >= (1 << FAIL_CNT_W)) begin : g_chk
    $error("FAIL_TIMEOUT_CYCLES out of range");
  end

  typedef struct packed {
    logic [NUM_SRC-1:0] sync1;
    logic [NUM_SRC-1:0] sync2;
    logic [NUM_SRC-1:0] prev;
    logic pin_sync1;
    logic pin_sync2;
    logic captured;
    logic [2:0] mode;
    logic [10:0] ost_cnt;
    logic stable;
    logic [FAIL_CNT_W-1:0] fail_cnt;
    logic failed;
    switch_state_t sw;
    logic [2:0] cur;
    logic [2:0] target;
    logic sysclk;
    logic run;
    logic [1:0] gain;
    logic mult;
    logic pin_o;
    logic pin_oe;
  } state_t;

  localparam state_t RESET_STATE = '{
    sync1: '0, sync2: '0, prev: '0, pin_sync1: 1'b0, pin_sync2: 1'b0,
    captured: 1'b0, mode: MODE_RESET, ost_cnt: 11'h000, stable: 1'b0,
    fail_cnt: '0, failed: 1'b0, sw: SW_RUN, cur: SRC_FAST, target: SRC_FAST,
    sysclk: 1'b0, run: 1'b0, gain: GAIN_OFF, mult: 1'b0, pin_o: 1'b0,
    pin_oe: 1'b0
  };

  state_t s;
  state_t next_s;

  // ****************************************
  // helpers
  // ****************************************
  logic [NUM_SRC-1:0] raw_src;
  logic crystal;
  logic early_internal;
  logic prim_rise;
  logic monitoring;
  logic [2:0] int_src;
  logic [2:0] want;

  assign raw_src = {internal_slow_source_in, internal_mid_source_in,
                    internal_fast_source_in, timer_osc_in, primary_osc_input_in};
  assign crystal = (s.mode == MODE_WATCH_CRYSTAL) || (s.mode == MODE_MEDIUM_GAIN) ||
                   (s.mode == MODE_HIGH_GAIN);
  assign early_internal = fail_safe_enable_in | two_speed_enable_in;
  assign prim_rise = s.sync2[SRC_PRIMARY] & ~s.prev[SRC_PRIMARY];
  assign monitoring = s.captured && (s.mode != MODE_INTERNAL) && fail_safe_enable_in &&
                      s.stable;
  assign int_src = (internal_freq_select_in == IFREQ_FAST) ? SRC_FAST :
                   (internal_freq_select_in == IFREQ_MID) ? SRC_MID : SRC_SLOW;

  always_comb begin
    if (s.failed) begin
      want = int_src;
    end else if (runtime_clock_select_in[SEL_INTERNAL_BIT]) begin
      want = int_src;
    end else if (runtime_clock_select_in == SEL_TIMER) begin
      want = SRC_TIMER;
    end else if (s.mode == MODE_INTERNAL) begin
      want = int_src;
    end else if (crystal && !s.stable && early_internal) begin
      want = int_src;
    end else begin
      want = SRC_PRIMARY;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.sync1 = raw_src;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    next_s.pin_sync1 = secondary_osc_pin_in;
    next_s.pin_sync2 = s.pin_sync1;
    // boot field captured once after reset release
    if (!s.captured) begin
      next_s.captured = 1'b1;
      next_s.mode = boot_clock_mode_field_in;
      next_s.stable = !((boot_clock_mode_field_in == MODE_WATCH_CRYSTAL) ||
                        (boot_clock_mode_field_in == MODE_MEDIUM_GAIN) ||
                        (boot_clock_mode_field_in == MODE_HIGH_GAIN));
      next_s.ost_cnt = 11'h000;
    end else if (wake_from_sleep_in) begin
      next_s.ost_cnt = 11'h000;
      next_s.stable = !crystal;
    end else if (!s.stable && prim_rise) begin
      next_s.ost_cnt = s.ost_cnt + 11'h001;
      if (s.ost_cnt == OST_COUNT - 11'h001) begin
        next_s.stable = 1'b1;
      end
    end
    // fail-safe watchdog on the primary input
    if (!monitoring || prim_rise) begin
      next_s.fail_cnt = '0;
    end else if (s.fail_cnt == FAIL_LAST) begin
      next_s.failed = 1'b1;
    end else begin
      next_s.fail_cnt = s.fail_cnt + 1'b1;
    end
    // glitch-free source switch; a halted source simply holds the output
    case (s.sw)
      SW_RUN: begin
        next_s.sysclk = s.sync2[s.cur];
        if (s.captured && want != s.cur) begin
          next_s.target = want;
          next_s.sw = SW_DRAIN;
        end
      end
      SW_DRAIN: begin
        next_s.target = want;
        // old source may only finish its high phase, never start a new one
        if (!s.sysclk || !s.sync2[s.cur] || s.failed) begin
          next_s.sysclk = 1'b0;
          next_s.sw = SW_ADOPT;
        end else begin
          next_s.sysclk = s.sync2[s.cur];
        end
      end
      SW_ADOPT: begin
        next_s.sysclk = 1'b0;
        next_s.target = want;
        if (s.prev[want] && !s.sync2[want]) begin
          next_s.cur = want;
          next_s.sw = SW_RUN;
        end
      end
      default: begin
        next_s.sw = SW_RUN;
      end
    endcase
    next_s.run = s.captured && (s.stable || (crystal && early_internal));
    case (s.mode)
      MODE_WATCH_CRYSTAL: next_s.gain = GAIN_LOW;
      MODE_MEDIUM_GAIN: next_s.gain = GAIN_MID;
      MODE_HIGH_GAIN: next_s.gain = GAIN_HIGH;
      default: next_s.gain = GAIN_OFF;
    endcase
    next_s.mult = nv_multiplier_enable_in | sw_multiplier_enable_in;
    if (crystal) begin
      next_s.pin_o = 1'b0;
      next_s.pin_oe = 1'b0;
    end else if (clkout_enable_in) begin
      next_s.pin_o = s.sysclk;
      next_s.pin_oe = 1'b1;
    end else begin
      next_s.pin_o = gpio_data_in;
      next_s.pin_oe = gpio_drive_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign system_clock_out = s.sysclk;
  assign run_enable_out = s.run;
  assign gain_select_out = s.gain;
  assign multiplier_enable_out = s.mult;
  assign clock_failed_out = s.failed;
  assign startup_stable_out = s.stable;
  assign active_source_out = s.cur;
  assign secondary_osc_pin_out = s.pin_o;
  assign secondary_osc_pin_oe_out = s.pin_oe;
  assign secondary_pin_sample_out = s.pin_sync2;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_boot_mode_capture: assert property ($rose(s.captured) |-> s.mode == $past(boot_clock_mode_field_in, 1))
    else $error("boot mode not captured");
  a_ext_no_startup: assert property (s.captured && s.mode >= MODE_EXT_LOW |-> s.stable)
    else $error("external clock mode waits on start-up");
  a_ost_holds_run: assert property (s.captured && crystal && !s.stable && !early_internal |=> !run_enable_out)
    else $error("run while crystal unstable");
  a_gain_by_mode: assert property (s.captured && $past(s.captured) |-> gain_select_out ==
      ((s.mode == MODE_WATCH_CRYSTAL) ? GAIN_LOW : (s.mode == MODE_MEDIUM_GAIN) ? GAIN_MID :
       (s.mode == MODE_HIGH_GAIN) ? GAIN_HIGH : GAIN_OFF))
    else $error("gain does not match mode");
  a_mult_enable: assert property (nv_multiplier_enable_in |=> multiplier_enable_out)
    else $error("nv multiplier bit ignored");
  a_fail_detect: assert property (monitoring && s.fail_cnt == FAIL_LAST && !prim_rise |=> clock_failed_out)
    else $error("lost clock not flagged");
  a_fail_fallback: assert property (s.failed && s.sw != SW_RUN |=> s.target == $past(int_src))
    else $error("no fallback to internal");
  a_clean_switch: assert property ($rose(system_clock_out) |-> $past(s.sw) == SW_RUN)
    else $error("clock high during switch");
  a_clkout_pin: assert property (s.captured && !crystal && clkout_enable_in |=>
      secondary_osc_pin_oe_out && secondary_osc_pin_out == $past(s.sysclk))
    else $error("clock out pin wrong");

  c_timer_switch: cover property (s.sw == SW_ADOPT ##1 s.sw == SW_RUN && s.cur == SRC_TIMER);
  c_fail: cover property ($rose(clock_failed_out));
  c_ost_done: cover property (crystal && $rose(startup_stable_out));
  c_clkout: cover property (secondary_osc_pin_oe_out && $rose(secondary_osc_pin_out));

endmodule

`default_nettype wire

/* ext_clock_source_model.sv */
// Purpose: behavioural external oscillator or logic clock
// Assumes: half period is counted in supervisory cycles
// Notes: a halted source is held low, as a stopped logic clock
`timescale 1ns/10ps
`default_nettype none
module ext_clock_source_model #(
  parameter int HALF = 2
) (
  // supervisory clock and control
  input wire logic sys_clk_in,
  input wire logic run_in,
  // oscillator level
  output logic osc_out
);
  int cnt = 0;
  initial osc_out = 1'b0;
  // ****
  // free running source, stops low
  // ****
  always @(posedge sys_clk_in) begin
    #3;
    if (!run_in) begin
      osc_out = 1'b0;
      cnt = 0;
    end else if (++cnt >= HALF) begin
      osc_out = ~osc_out;
      cnt = 0;
    end
  end
endmodule
`default_nettype wire

/* system_clock_source_selector_tb.sv */
// Purpose: self-checking bench for the clock source selector
// Assumes: primary and timer sources come from the source model
// Notes: crystal start-up runs about 1024 primary periods per mode
`timescale 1ns/10ps
`default_nettype none
module system_clock_source_selector_tb;
  import clock_selector_pkg::*;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [2:0] mode = 3'h7;
  logic nvm = 1'b0, cko = 1'b0, fse = 1'b0, swm = 1'b0, prun = 1'b1;
  logic pin = 1'b0, gd = 1'b0, gdr = 1'b0, v, p_osc, t_osc;
  logic tse = 1'b0, wake = 1'b0, psmp;
  logic [1:0] rsel = 2'h0, ifs = 2'h0, gain;
  logic [4:0] isrc = 5'h0;
  logic sclk, run, mult, failed, stable, pin_o, pin_oe;
  logic [2:0] asrc;
  logic [7:0] lfsr = 8'h40;
  logic [3:0] tab [5] = '{4'h4, 4'h8, 4'hd, 4'he, 4'h0};
  int fails = 0;
  int checked = 0;
  int n;
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) #1 isrc = isrc + 5'h1;
  ext_clock_source_model #(.HALF(2)) ext_clock_source_model_inst (
    .sys_clk_in(sys_clk_in), .run_in(prun), .osc_out(p_osc));
  ext_clock_source_model #(.HALF(5)) timer_source_inst (
    .sys_clk_in(sys_clk_in), .run_in(1'b1), .osc_out(t_osc));
  system_clock_source_selector #(.FAIL_TIMEOUT_CYCLES(20)) system_clock_source_selector_inst (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .boot_clock_mode_field_in(mode),
    .nv_multiplier_enable_in(nvm), .clkout_enable_in(cko), .fail_safe_enable_in(fse),
    .two_speed_enable_in(tse), .runtime_clock_select_in(rsel),
    .internal_freq_select_in(ifs), .sw_multiplier_enable_in(swm),
    .wake_from_sleep_in(wake), .primary_osc_input_in(p_osc), .timer_osc_in(t_osc),
    .internal_fast_source_in(isrc[1]), .internal_mid_source_in(isrc[2]),
    .internal_slow_source_in(isrc[4]), .secondary_osc_pin_in(pin), .gpio_data_in(gd),
    .gpio_drive_in(gdr), .system_clock_out(sclk), .run_enable_out(run),
    .gain_select_out(gain), .multiplier_enable_out(mult), .clock_failed_out(failed),
    .startup_stable_out(stable), .active_source_out(asrc), .secondary_osc_pin_out(pin_o),
    .secondary_osc_pin_oe_out(pin_oe), .secondary_pin_sample_out(psmp));
  // ****
  // helpers
  // ****
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic boot(input logic [2:0] m);
    @(posedge sys_clk_in);
    #1 arst_n_in = 1'b0;
    mode = m;
    repeat (6) @(posedge sys_clk_in);
    #1 chk("reset run", 3'(run), 3'h0);
    chk("reset src", asrc, SRC_FAST);
    arst_n_in = 1'b1;
  endtask
  task automatic wait_src(input logic [2:0] e);
    n = 0;
    while (asrc !== e && n < 200) begin
      @(posedge sys_clk_in);
      n++;
    end
    #1 chk("source", asrc, e);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge sys_clk_in);
      n++;
    end
    #1 chk("flag", 3'(s), 3'h1);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    fails++;
    final_report();
  end
  // ****
  // tests
  // ****
  initial begin
    boot(3'h7);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_in);
      #1 {swm, nvm} = 2'(i);
      repeat (2) @(posedge sys_clk_in);
      #1 chk("mult", 3'(mult), 3'(i != 0));
    end
    $display("test multiplier done");
    for (int m = 3; m < 8; m++) begin
      cko = m[0];
      boot(3'(m));
      repeat (3) @(posedge sys_clk_in);
      #1 chk("stable", 3'(stable), 3'h1);
      chk("run", 3'(run), 3'h1);
      chk("gain", 3'(gain), 3'h0);
      wait_src((m == 4) ? SRC_FAST : SRC_PRIMARY);
      repeat (6) begin
        @(posedge sys_clk_in);
        #1 lfsr = nxt(lfsr);
        {pin, gdr, gd} = lfsr[2:0];
        @(posedge sys_clk_in);
        #1 chk("pin oe", 3'(pin_oe), 3'(cko | gdr));
        if (!cko) chk("pin out", 3'(pin_o), 3'(gd));
        @(posedge sys_clk_in);
        #1 chk("pin sample", 3'(psmp), 3'(pin));
      end
      $display("test mode %0d done", m);
    end
    for (int m = 0; m < 3; m++) begin
      boot(3'(m));
      repeat (4000) @(posedge sys_clk_in);
      #1 chk("gain", 3'(gain), 3'(m + 1));
      chk("early", 3'(stable | run), 3'h0);
      wait_hi(stable, 300);
      repeat (2) @(posedge sys_clk_in);
      #1 chk("run", 3'(run), 3'h1);
      $display("test crystal %0d done", m);
    end
    // wake restarts the count; two-speed runs on internal meanwhile
    @(posedge sys_clk_in);
    #1 wake = 1'b1;
    tse = 1'b1;
    @(posedge sys_clk_in);
    #1 wake = 1'b0;
    @(posedge sys_clk_in);
    #1 chk("wake stable", 3'(stable), 3'h0);
    chk("two speed run", 3'(run), 3'h1);
    wait_src(SRC_FAST);
    wait_hi(stable, 4300);
    wait_src(SRC_PRIMARY);
    tse = 1'b0;
    $display("test wake done");
    boot(3'h7);
    for (int k = 0; k < 5; k++) begin
      @(posedge sys_clk_in);
      #1 {rsel, ifs} = tab[k];
      wait_src(3'((k + 1) % 5));
    end
    prun = 1'b0;
    repeat (6) @(posedge sys_clk_in);
    #1 v = sclk;
    repeat (40) @(posedge sys_clk_in);
    #1 chk("frozen", 3'(sclk), 3'(v));
    chk("no fail", 3'(failed), 3'h0);
    prun = 1'b1;
    $display("test switch and halt done");
    fse = 1'b1;
    boot(3'h7);
    repeat (10) @(posedge sys_clk_in);
    #1 prun = 1'b0;
    wait_hi(failed, 100);
    wait_src(SRC_FAST);
    rsel = SEL_TIMER;
    repeat (20) @(posedge sys_clk_in);
    #1 chk("forced", asrc, SRC_FAST);
    $display("test fail safe done");
    final_report();
  end
endmodule
`default_nettype wire
